// >>> verilog/stf_pkg.sv
// constants, types and helper functions shared by the soft trap status block
package stf_pkg;

    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int DATA_W = 32; // classic wishbone data width
    localparam int ADDR_W = 8; // byte address width seen by the slave

    // ------------------------------------------------------------------
    // register byte offsets, one aligned word each
    // ------------------------------------------------------------------
    localparam logic [7:0] STATUS_OFS = 8'h00; // soft_trap_status
    localparam logic [7:0] IRQ_PEND_OFS = 8'h04; // sticky interrupt pending, write one to clear
    localparam logic [7:0] IRQ_MASK_OFS = 8'h08; // interrupt mask, same layout

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int NAE_BIT = 8; // nvm_address_error_flag
    localparam int OVF_BIT = 4; // loop_stack_overflow_flag
    localparam int PLL_BIT = 0; // aux_pll_unlock_flag
    localparam int NUM_FLAGS = 3; // implemented flags
    localparam logic [15:0] IMPL_MASK = 16'h0111; // implemented positions
    localparam logic [NUM_FLAGS-1:0] FLAGS_RST = 3'h0; // all flags clear at power-on
    localparam logic [NUM_FLAGS-1:0] MASK_RST = 3'h0; // all sources masked at reset

    // ------------------------------------------------------------------
    // trap event carrier, index 0 nvm, 1 loop stack, 2 aux pll
    // ------------------------------------------------------------------
    typedef struct packed {
        logic aux_pll_unlock; // aux pll lost lock
        logic loop_stack_overflow; // hardware loop stack overflowed
        logic nvm_address_error; // nvm address error
    } stf_trap_evt_t;

    // gather the three implemented positions of a 16-bit word
    function automatic logic [NUM_FLAGS-1:0] pick_flags(input logic [15:0] w);
        return {w[PLL_BIT], w[OVF_BIT], w[NAE_BIT]};
    endfunction : pick_flags

    // scatter three flags back to their positions, others read zero
    function automatic logic [15:0] place_flags(input logic [NUM_FLAGS-1:0] f);
        logic [15:0] w;
        w = 16'h0000;
        w[NAE_BIT] = f[0];
        w[OVF_BIT] = f[1];
        w[PLL_BIT] = f[2];
        return w;
    endfunction : place_flags

    // expand the two low byte enables to a bit mask
    function automatic logic [15:0] lane_bits(input logic [3:0] sel);
        return {{8{sel[1]}}, {8{sel[0]}}};
    endfunction : lane_bits

endpackage : stf_pkg

// >>> verilog/stf_edge_detect.sv
// rising edge detector turning trap request levels into one-cycle events
`timescale 1ns/10ps
module stf_edge_detect #(
    parameter int WIDTH = 3
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] pulse
);

    // ------------------------------------------------------------------
    // history and detection
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] prev_reg; // level seen one edge ago

    // a level held high counts once; a new trap needs a fresh rise
    assign pulse = level & ~prev_reg;

    // remember the previous level
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= level;
        end
    end

endmodule : stf_edge_detect

// >>> verilog/stf_sticky_bit.sv
// one sticky flag: hardware sets, software writes, set beats write
`timescale 1ns/10ps
module stf_sticky_bit #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic set,
    input wire logic wr_en,
    input wire logic wr_val,
    output logic q
);

    // ------------------------------------------------------------------
    // next value
    // ------------------------------------------------------------------
    logic q_reg; // stored flag
    logic q_next; // value after this edge

    // an event in the clearing cycle must not be lost, so set wins
    assign q_next = set ? 1'b1 : (wr_en ? wr_val : q_reg);
    assign q = q_reg;

    // flag storage
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q_reg <= RST_VAL;
        end else begin
            q_reg <= q_next;
        end
    end

endmodule : stf_sticky_bit

// >>> verilog/stf_soft_trap_status.sv
// soft trap status register with wishbone slave and masked interrupt
//
// Contract
// - nvm address error event sets bit 8
// - loop stack overflow event sets bit 4
// - aux pll unlock event sets bit 0
// - unimplemented bits read zero, writes ignored
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
module stf_soft_trap_status #(
    parameter int ADDR_W = stf_pkg::ADDR_W
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [ADDR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [stf_pkg::DATA_W-1:0] wb_dat_wr,
    output logic [stf_pkg::DATA_W-1:0] wb_dat_rd,
    output logic wb_ack,
    input wire stf_pkg::stf_trap_evt_t trap_evt,
    output logic [15:0] trap_flags,
    output logic irq
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    localparam int NF = stf_pkg::NUM_FLAGS; // flag count

    logic ack_reg; // wishbone acknowledge
    logic [stf_pkg::DATA_W-1:0] rd_reg; // registered read data
    logic irq_reg; // registered interrupt level
    logic [NF-1:0] mask_reg; // interrupt mask
    logic [NF-1:0] mask_next; // mask after a write

    logic [NF-1:0] evt_pulse; // one-cycle trap events
    logic [NF-1:0] flag_q; // trap status flags
    logic [NF-1:0] pend_q; // interrupt pending flags

    logic req; // a new access is on the bus
    logic wr_acc; // write accepted at this edge
    logic rd_acc; // read accepted at this edge
    logic [7:0] adr_word; // word-aligned byte address
    logic hit_status; // access hits soft_trap_status
    logic hit_pend; // access hits pending register
    logic hit_mask; // access hits mask register
    logic stat_wr; // write to status accepted
    logic pend_wr; // write to pending accepted
    logic mask_wr; // write to mask accepted
    logic [NF-1:0] wen_flags; // byte enables at flag positions
    logic [NF-1:0] wdat_flags; // write data at flag positions
    logic [stf_pkg::DATA_W-1:0] rd_word; // selected read word
    logic irq_next; // unmasked pending present

    // ------------------------------------------------------------------
    // trap event detection
    // ------------------------------------------------------------------

    // request levels from the nvm controller, loop stack and lock detector
    stf_edge_detect #(
        .WIDTH(NF)
    ) u_edge (
        .core_clk(core_clk),
        .nrst(nrst),
        .level(trap_evt),
        .pulse(evt_pulse)
    );

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------

    // a request is new while ack has not yet been given for it
    assign req = wb_cyc & wb_stb & ~ack_reg;
    assign wr_acc = req & wb_we;
    assign rd_acc = req & ~wb_we;

    // low two address bits ignored: every register is one aligned word
    assign adr_word = {wb_adr[7:2], 2'b00};
    assign hit_status = (adr_word == stf_pkg::STATUS_OFS);
    assign hit_pend = (adr_word == stf_pkg::IRQ_PEND_OFS);
    assign hit_mask = (adr_word == stf_pkg::IRQ_MASK_OFS);

    // per-register write strobes
    assign stat_wr = wr_acc & hit_status;
    assign pend_wr = wr_acc & hit_pend;
    assign mask_wr = wr_acc & hit_mask;

    // only implemented positions are looked at, the rest of a write is dropped
    assign wen_flags = stf_pkg::pick_flags(stf_pkg::lane_bits(wb_sel));
    assign wdat_flags = stf_pkg::pick_flags(wb_dat_wr[15:0]);

    // ------------------------------------------------------------------
    // trap status flags
    // ------------------------------------------------------------------

    // each flag is sticky; a software write of 0 or 1 replaces it
    genvar gi;
    generate
        for (gi = 0; gi < NF; gi++) begin : g_flag
            // index 0 is nvm, 1 loop stack, 2 aux pll
            stf_sticky_bit #(
                .RST_VAL(stf_pkg::FLAGS_RST[gi])
            ) u_flag (
                .core_clk(core_clk),
                .nrst(nrst),
                .set(evt_pulse[gi]),
                .wr_en(stat_wr & wen_flags[gi]),
                .wr_val(wdat_flags[gi]),
                .q(flag_q[gi])
            );

            // interrupt pending copy, cleared by writing a one
            stf_sticky_bit #(
                .RST_VAL(1'b0)
            ) u_pend (
                .core_clk(core_clk),
                .nrst(nrst),
                .set(evt_pulse[gi]),
                .wr_en(pend_wr & wen_flags[gi] & wdat_flags[gi]),
                .wr_val(1'b0),
                .q(pend_q[gi])
            );
        end
    endgenerate

    // flags sit at their positions, unimplemented ones tied to zero
    assign trap_flags = stf_pkg::place_flags(flag_q);

    // ------------------------------------------------------------------
    // mask and interrupt
    // ------------------------------------------------------------------

    // byte-enabled mask write, only implemented positions stored
    assign mask_next = mask_wr ? ((mask_reg & ~wen_flags) | (wdat_flags & wen_flags)) : mask_reg;

    // the level lags pending by one edge so that irq comes from a flop
    assign irq_next = |(pend_q & mask_reg);

    // ------------------------------------------------------------------
    // read select
    // ------------------------------------------------------------------

    // unmapped addresses read zero and still get an ack
    assign rd_word = hit_status ? {16'h0000, stf_pkg::place_flags(flag_q)} :
                     hit_pend ? {16'h0000, stf_pkg::place_flags(pend_q)} :
                     hit_mask ? {16'h0000, stf_pkg::place_flags(mask_reg)} :
                     32'h0000_0000;

    // ------------------------------------------------------------------
    // bus response and control registers
    // ------------------------------------------------------------------

    // ack one edge after the request, dropped the edge after that
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
            rd_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req;
            rd_reg <= rd_acc ? rd_word : 32'h0000_0000;
        end
    end

    // mask and interrupt level
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mask_reg <= stf_pkg::MASK_RST;
            irq_reg <= 1'b0;
        end else begin
            mask_reg <= mask_next;
            irq_reg <= irq_next;
        end
    end

    assign wb_ack = ack_reg;
    assign wb_dat_rd = rd_reg;
    assign irq = irq_reg;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    // nvm address error event shows in bit 8 at the next edge
    nae_set_a: assert property (
        evt_pulse[0] |=> trap_flags[stf_pkg::NAE_BIT]
    ) else $error("nvm address error flag not set");

    // nvm flag stays low while no event and no write came
    nae_quiet_a: assert property (
        (!trap_flags[stf_pkg::NAE_BIT] && !evt_pulse[0] && !stat_wr)
            |=> !trap_flags[stf_pkg::NAE_BIT]
    ) else $error("nvm address error flag set without cause");

    // loop stack overflow event shows in bit 4 at the next edge
    ovf_set_a: assert property (
        evt_pulse[1] |=> trap_flags[stf_pkg::OVF_BIT]
    ) else $error("loop stack overflow flag not set");

    // aux pll unlock rising level shows in bit 0 at the next edge
    pll_set_a: assert property (
        $rose(trap_evt.aux_pll_unlock) |-> ##1 trap_flags[stf_pkg::PLL_BIT]
    ) else $error("aux pll unlock flag not set");

    // unimplemented positions of the status output never rise
    unimpl_zero_a: assert property (
        (trap_flags & ~stf_pkg::IMPL_MASK) == 16'h0000
    ) else $error("unimplemented status bit set");

    // a read of the status word returns zero in all unused bits
    rd_unimpl_a: assert property (
        (wb_ack && !wb_we && hit_status)
            |-> (wb_dat_rd & ~{16'h0000, stf_pkg::IMPL_MASK}) == 32'h0000_0000
    ) else $error("status read shows unimplemented bit");

    // read data of the status word matches the flags held one edge before
    rd_value_a: assert property (
        (rd_acc && hit_status) |=> wb_dat_rd[15:0] == $past(trap_flags)
    ) else $error("status read data wrong");

    // without a write, no flag ever falls
    flag_hold_a: assert property (
        !stat_wr |=> (flag_q & $past(flag_q)) == $past(flag_q)
    ) else $error("trap flag cleared without a write");

    // a full-lane write with no event stores exactly the written flags
    sw_write_a: assert property (
        (stat_wr && wb_sel[1:0] == 2'b11 && evt_pulse == '0)
            |=> flag_q == $past(wdat_flags)
    ) else $error("software write not stored");

    // an aux pll event in the clearing cycle wins over the clear
    set_wins_a: assert property (
        (evt_pulse[2] && stat_wr && wen_flags[2] && !wdat_flags[2])
            |=> flag_q[2]
    ) else $error("event lost against a clear");

    // ack follows a request by one edge and lasts one cycle
    ack_pulse_a: assert property (
        req |=> wb_ack ##1 !wb_ack
    ) else $error("ack timing wrong");

    // interrupt follows unmasked pending, high or low, one edge later
    irq_level_a: assert property (
        (|(pend_q & mask_reg)) |=> irq
    ) else $error("interrupt missing");

    irq_low_a: assert property (
        !(|(pend_q & mask_reg)) |=> !irq
    ) else $error("interrupt without pending source");

    // write-one-to-clear removes pending bits written with one
    pend_w1c_a: assert property (
        (pend_wr && wb_sel[1:0] == 2'b11 && evt_pulse == '0)
            |=> (pend_q & $past(wdat_flags)) == '0
    ) else $error("pending bit not cleared");

    // loop stack flag stays low while no event and no write came
    ovf_quiet_a: assert property (
        (!trap_flags[stf_pkg::OVF_BIT] && !evt_pulse[1] && !stat_wr)
            |=> !trap_flags[stf_pkg::OVF_BIT]
    ) else $error("loop stack overflow flag set without cause");

    // aux pll flag stays low while no event and no write came
    pll_quiet_a: assert property (
        (!trap_flags[stf_pkg::PLL_BIT] && !evt_pulse[2] && !stat_wr)
            |=> !trap_flags[stf_pkg::PLL_BIT]
    ) else $error("aux pll unlock flag set without cause");

    // a detected aux pll event lands in bit 0 at the next edge
    pll_pulse_a: assert property (
        evt_pulse[2] |=> trap_flags[stf_pkg::PLL_BIT]
    ) else $error("aux pll unlock event lost");

    // every trap event also marks its pending bit
    pend_set_a: assert property (
        (evt_pulse != '0) |=> (pend_q & $past(evt_pulse)) == $past(evt_pulse)
    ) else $error("pending bit not set by event");

    // without a pending write, no pending bit ever falls
    pend_hold_a: assert property (
        !pend_wr |=> (pend_q & $past(pend_q)) == $past(pend_q)
    ) else $error("pending bit cleared without a write");

    // a full-lane mask write stores exactly the written positions
    mask_wr_a: assert property (
        (mask_wr && wb_sel[1:0] == 2'b11) |=> mask_reg == $past(wdat_flags)
    ) else $error("mask write not stored");

    // read data is zero outside the ack cycle, so stale words never leak
    rd_idle_a: assert property (
        !wb_ack |-> wb_dat_rd == 32'h0000_0000
    ) else $error("read data outside ack");

    // ack only ever answers a request taken one edge before
    ack_cause_a: assert property (
        wb_ack |-> $past(req)
    ) else $error("ack without request");

endmodule : stf_soft_trap_status

// >>> test/test_stf_soft_trap_status.sv
// self-checking bench for the soft trap status register block
`timescale 1ns/10ps
module test_stf_soft_trap_status;
    // ------------------------------------------------------------------
    // stimulus, observed outputs and bench state
    // ------------------------------------------------------------------
    logic core_clk = 1'b0; // 10 mhz system clock
    logic nrst = 1'b0; // held low for the first cycles
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_wr = 32'h0000_0000;
    logic [2:0] evt = 3'h0; // trap request levels, 0 nvm, 1 loop stack, 2 aux pll
    logic [31:0] wb_dat_rd;
    logic wb_ack;
    logic [15:0] trap_flags;
    logic irq;
    int err_count = 0; // mismatches seen
    int n_compared = 0; // comparisons made
    int cycles = 0; // hang guard
    int st_m = 0; // model of the status flags
    int pend_m = 0; // model of the pending bits
    int mask_m = 0; // model of the mask bits
    int pos_q[3] = '{8, 4, 0}; // flag position of each event source
    localparam logic [15:0] IMPL = 16'h0111; // positions that store a value

    stf_soft_trap_status uut (.core_clk(core_clk), .nrst(nrst), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_wr(wb_dat_wr), .wb_dat_rd(wb_dat_rd), .wb_ack(wb_ack),
        .trap_evt(evt), .trap_flags(trap_flags), .irq(irq));

    // free running clock, 100 ns period
    initial begin
        forever #50 core_clk = ~core_clk;
    end

    // cut a hang short; the whole run needs well under this many cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            $display("mismatch timeout expected %0d seen %0d", 19999, cycles);
            finish_test();
        end
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    // count one comparison, report it if it differs
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one classic wishbone cycle; data taken at the edge where ack is seen
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r);
        @(posedge core_clk);
        check("ack idle", {31'h0, wb_ack}, 32'h0000_0000);
        check("read data idle", wb_dat_rd, 32'h0000_0000);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= s;
        wb_dat_wr <= d;
        do begin
            @(posedge core_clk);
        end while (wb_ack !== 1'b1);
        r = wb_dat_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb

    // write through the bus and follow it in the model, per byte lane
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        int lm;
        wb(1'b1, a, d, s, r);
        lm = {{8{s[1]}}, {8{s[0]}}} & IMPL;
        case (a)
            8'h00: st_m = (st_m & ~lm) | (d[15:0] & lm);
            8'h04: pend_m = pend_m & ~(d[15:0] & lm);
            8'h08: mask_m = (mask_m & ~lm) | (d[15:0] & lm);
            default: ; // unmapped: nothing stored
        endcase
    endtask : wr

    // read through the bus and compare with the model
    task automatic rd_chk(input logic [7:0] a);
        logic [31:0] r;
        wb(1'b0, a, 32'h0000_0000, 4'hf, r);
        case (a)
            8'h00: check("status", r, st_m);
            8'h04: check("pending", r, pend_m);
            8'h08: check("mask", r, mask_m);
            default: check("unmapped", r, 32'h0000_0000);
        endcase
    endtask : rd_chk

    // one-cycle trap request on the chosen sources, then low again
    task automatic pulse(input logic [2:0] bits);
        @(posedge core_clk);
        evt <= bits;
        @(posedge core_clk);
        evt <= '0;
        for (int i = 0; i < 3; i++) begin
            if (bits[i]) begin
                st_m = st_m | (1 << pos_q[i]);
                pend_m = pend_m | (1 << pos_q[i]);
            end
        end
    endtask : pulse

    // let the registered outputs catch up, then compare them
    task automatic settle();
        repeat (3) @(posedge core_clk);
        check("trap_flags", {16'h0000, trap_flags}, st_m);
        check("irq", {31'h0, irq}, {31'h0, (pend_m & mask_m) != 0});
    endtask : settle

    // print the counts and the verdict, then stop
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(80));
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        // power-on values of every register
        for (int a = 0; a < 3; a++) begin
            rd_chk(8'(a * 4));
        end
        settle();
        // a held level counts once: a clear during the hold must stick
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            evt[i] <= 1'b1;
            st_m = st_m | (1 << pos_q[i]);
            pend_m = pend_m | (1 << pos_q[i]);
            repeat (4) @(posedge core_clk);
            settle();
            wr(8'h00, 32'h0000_0000, 4'h3);
            settle();
            @(posedge core_clk);
            evt[i] <= 1'b0;
            pulse(3'(1 << i));
            rd_chk(8'h00);
        end
        // all ones land only on implemented positions
        wr(8'h00, 32'hffff_ffff, 4'hf);
        rd_chk(8'h00);
        // lane 0 only: bit 8 must survive
        wr(8'h00, 32'h0000_0000, 4'h1);
        rd_chk(8'h00);
        // interrupt path: unmask, clear one, then the rest at once, then a fresh event
        wr(8'h08, 32'h0000_0111, 4'h3);
        settle();
        wr(8'h04, 32'h0000_0010, 4'h3);
        rd_chk(8'h04);
        wr(8'h04, 32'h0000_ffff, 4'hf);
        settle();
        pulse(3'b010);
        settle();
        // an event in the clearing cycle wins, for status and pending alike
        for (int j = 0; j < 2; j++) begin
            fork
                wr(8'(j * 4), 32'h0000_0111 * j, 4'h3);
                begin
                    @(posedge core_clk);
                    evt <= 3'b111;
                end
            join
            st_m = st_m | 32'h0000_0111;
            pend_m = pend_m | 32'h0000_0111;
            evt <= 3'b000;
            settle();
            rd_chk(8'(j * 4));
        end
        // unmapped address: ignored write, zero read
        wr(8'h0c, 32'hffff_ffff, 4'hf);
        rd_chk(8'h0c);
        rd_chk(8'h00);
        // random mix of writes, reads and events
        for (int k = 0; k < 80; k++) begin
            case ($urandom_range(0, 2))
                0: wr(8'($urandom_range(0, 3)) << 2, $urandom, 4'($urandom_range(0, 15)));
                1: pulse(3'($urandom_range(1, 7)));
                default: rd_chk(8'($urandom_range(0, 3)) << 2);
            endcase
            settle();
        end
        // reset in mid-run clears everything again
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        st_m = 0;
        pend_m = 0;
        mask_m = 0;
        rd_chk(8'h00);
        rd_chk(8'h08);
        rd_chk(8'h04);
        settle();
        finish_test();
    end
endmodule : test_stf_soft_trap_status
